/* File: shared/usb_irq_pkg.sv */
// package: register map, field layout and timing for device interrupt routing
// Functional notes
// R01 - A status bit raises an interrupt line only while its enable bit is one.
// R02 - Enabled interrupts go to the low-priority line unless priority selects otherwise.
// R03 - Writing one to a clear bit clears that status bit; zero leaves it alone.
// R04 - Writing one to a force bit sets that status bit; zero does nothing.
// R05 - Priority bit 0 sends the frame interrupt to the high line when one, else low.
// R06 - Priority bit 1 sends the fast-endpoint interrupt to the high line; resets to zero.
// R07 - With both priority bits one, nothing is routed to the high-priority line.
// R08 - Software clears per-endpoint bits before clearing the slow or fast status bit.
// R09 - The enable register is read/write and resets to all zero.
// R10 - The priority register is write-only and reads do not return it.
// R11 - Software writes no ones to priority bits 7 to 2; reads of them are undefined.
// R12 - The status register is read-only; a bit reads one while its event is pending.
// R13 - The frame status bit is raised once every millisecond.
// R14 - The command-register-empty status bit resets to one.
// R15 - Each line is the OR of status bits enabled and routed to it, bits 9 to 0.
// R16 - A set event wins over a clear of the same bit in the same cycle.
package usb_irq_pkg;

	// ************************************************************
	// register byte addresses
	// ************************************************************
	localparam logic [31:0] STATUS_ADDR = 32'he010c200;
	localparam logic [31:0] ENABLE_ADDR = 32'he010c204;
	localparam logic [31:0] CLEAR_ADDR = 32'he010c208;
	localparam logic [31:0] FORCE_ADDR = 32'he010c20c;
	localparam logic [31:0] PRIORITY_ADDR = 32'he010c22c;
	localparam logic [31:0] LINE_STATUS_ADDR = 32'he010c2fc;

	// ************************************************************
	// field layout
	// ************************************************************
	localparam int EVENT_COUNT = 10;
	localparam int FRAME_BIT = 0;
	localparam int FAST_BIT = 1;
	localparam int SLOW_BIT = 2;
	localparam int BUS_STATE_BIT = 3;
	localparam int CMD_EMPTY_BIT = 4;
	localparam int PRIO_FRAME_BIT = 0;
	localparam int PRIO_FAST_BIT = 1;
	localparam int LINE_LOW_BIT = 0;
	localparam int LINE_HIGH_BIT = 1;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [9:0] STATUS_RESET = 10'h010;
	localparam logic [9:0] ENABLE_RESET = 10'h000;
	localparam logic [1:0] PRIORITY_RESET = 2'h0;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLOCK_PERIOD_NS = 40;
	localparam int FRAME_PERIOD_NS = 1000000;
	localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLOCK_PERIOD_NS;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bus_write_type;

	typedef struct packed {
		logic low;
		logic high;
	} irq_lines_type;

endpackage

/* File: rtl/usb_frame_tick.sv */
// module: free-running frame period pulse generator
`timescale 1ns/1ns
`default_nettype none
module usb_frame_tick #(
	parameter int PERIOD_CYCLES = usb_irq_pkg::FRAME_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// one-cycle pulse per period
	output logic tick
);

	logic [31:0] count;
	wire logic atEnd = (count == 32'(PERIOD_CYCLES - 1));

	// R13 frame period count
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count <= 32'h0;
			tick <= 1'b0;
		end else begin
			count <= atEnd ? 32'h0 : count + 32'h1;
			tick <= atEnd;
		end
	end

endmodule
`default_nettype wire

/* File: rtl/usb_irq_ahb_slave.sv */
// module: AHB-Lite slave front end, one wait state on reads
`timescale 1ns/1ns
`default_nettype none
module usb_irq_ahb_slave (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// AHB-Lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// register side
	output usb_irq_pkg::bus_write_type wr,
	output logic [31:0] rdAddr,
	input wire logic [31:0] rdValue
);

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WRITE = 4'b0010,
		ST_READ_WAIT = 4'b0100,
		ST_READ_DONE = 4'b1000
	} slave_state_type;

	slave_state_type state;
	slave_state_type next_state;
	logic [31:0] addr;

	// only word transfers are supported; hsize is not checked
	wire logic take = hsel & hready & htrans[1];

	always_comb begin
		case (state)
			ST_READ_WAIT: next_state = ST_READ_DONE;
			ST_IDLE, ST_WRITE, ST_READ_DONE: begin
				if (take) begin
					next_state = hwrite ? ST_WRITE : ST_READ_WAIT;
				end else begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// read data registered one cycle after the address phase, so a
	// write just before it has already landed
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			addr <= 32'h0;
			hrdata <= 32'h0;
		end else begin
			state <= next_state;
			if (take) begin
				addr <= haddr;
			end
			if (state == ST_READ_WAIT) begin
				hrdata <= rdValue;
			end
		end
	end

	// reads stall one cycle while the read mux output is registered
	assign hreadyout = (state != ST_READ_WAIT);
	assign hresp = 1'b0;
	assign rdAddr = addr;
	assign wr.write = (state == ST_WRITE);
	assign wr.addr = addr;
	assign wr.wdata = hwdata;

endmodule
`default_nettype wire

/* File: rtl/usb_device_irq_routing.sv */
// module: device interrupt status, enable, clear, force and priority routing
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module usb_device_irq_routing #(
	parameter int FRAME_CYCLES = usb_irq_pkg::FRAME_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,

	// AHB-Lite register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,

	// event pulses from the device engine, one bit per status bit
	input wire logic [9:0] eventPulse,

	// interrupt request lines
	output logic lowPriorityIrqLine,
	output logic highPriorityIrqLine,
	output logic usbIrq
);

	// ************************************************************
	// address decode helper
	// ************************************************************
	function automatic logic hit(input logic [31:0] a, input logic [31:0] offset);
		hit = (a == offset);
	endfunction

	// ************************************************************
	// bus front end
	// ************************************************************
	usb_irq_pkg::bus_write_type wr;
	logic [31:0] rdAddr;
	logic [31:0] rdValue;

	usb_irq_ahb_slave busSlave (
		.clock(clock),
		.arst_n(arst_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr(wr),
		.rdAddr(rdAddr),
		.rdValue(rdValue)
	);

	// ************************************************************
	// frame period source
	// ************************************************************
	logic frameTick;

	usb_frame_tick #(
		.PERIOD_CYCLES(FRAME_CYCLES)
	) frameGen (
		.clock(clock),
		.arst_n(arst_n),
		.tick(frameTick)
	);

	// ************************************************************
	// write strobes
	// ************************************************************
	wire logic writeEnable = wr.write & hit(wr.addr, usb_irq_pkg::ENABLE_ADDR);
	wire logic writeClear = wr.write & hit(wr.addr, usb_irq_pkg::CLEAR_ADDR);
	wire logic writeForce = wr.write & hit(wr.addr, usb_irq_pkg::FORCE_ADDR);
	wire logic writePriority = wr.write & hit(wr.addr, usb_irq_pkg::PRIORITY_ADDR);

	// R03 clear mask
	wire logic [9:0] clearMask = writeClear ? wr.wdata[9:0] : 10'h000;
	// R04 force mask
	wire logic [9:0] forceMask = writeForce ? wr.wdata[9:0] : 10'h000;

	// R13 frame tick joins the engine's own frame pulse
	wire logic [9:0] hwEvents = eventPulse | {9'h000, frameTick};

	// ************************************************************
	// status register
	// ************************************************************
	logic [9:0] status;
	logic [9:0] next_status;

	genvar i;
	generate
		for (i = 0; i < usb_irq_pkg::EVENT_COUNT; i++) begin : statusBit
			// R16 set beats clear
			assign next_status[i] = hwEvents[i] | forceMask[i] |
				(status[i] & ~clearMask[i]);
		end
	endgenerate

	// R14 command-empty resets high
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			status <= usb_irq_pkg::STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// ************************************************************
	// enable register
	// ************************************************************
	logic [9:0] enable;

	// R09 read/write, reset zero
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			enable <= usb_irq_pkg::ENABLE_RESET;
		end else if (writeEnable) begin
			enable <= wr.wdata[9:0];
		end
	end

	// ************************************************************
	// priority register
	// ************************************************************
	logic [1:0] routeSel;

	// R11 reserved bits 7:2 are dropped, not stored
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			routeSel <= usb_irq_pkg::PRIORITY_RESET;
		end else if (writePriority) begin
			routeSel <= wr.wdata[1:0];
		end
	end

	// ************************************************************
	// routing
	// ************************************************************
	// R05 frame to high line
	wire logic frameHigh = routeSel[usb_irq_pkg::PRIO_FRAME_BIT] &
		~routeSel[usb_irq_pkg::PRIO_FAST_BIT];
	// R06 fast endpoint to high line
	wire logic fastHigh = routeSel[usb_irq_pkg::PRIO_FAST_BIT] &
		~routeSel[usb_irq_pkg::PRIO_FRAME_BIT];

	// R07 both set routes nothing high; those two fall back to the low line
	logic [9:0] highMask;
	always_comb begin
		highMask = 10'h000;
		highMask[usb_irq_pkg::FRAME_BIT] = frameHigh;
		highMask[usb_irq_pkg::FAST_BIT] = fastHigh;
	end

	// R01 gate by enable
	wire logic [9:0] active = status & enable;

	// R02 everything not routed high goes low
	// R15 each line is the OR of its routed bits
	wire logic lowReq = |(active & ~highMask);
	wire logic highReq = |(active & highMask);

	usb_irq_pkg::irq_lines_type lines;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lines <= '0;
		end else begin
			lines.low <= lowReq;
			lines.high <= highReq;
		end
	end

	assign lowPriorityIrqLine = lines.low;
	assign highPriorityIrqLine = lines.high;
	assign usbIrq = lines.low | lines.high;

	// ************************************************************
	// read mux
	// ************************************************************
	// R12 status read-only: writes to its address are ignored
	wire logic readStatus = hit(rdAddr, usb_irq_pkg::STATUS_ADDR);
	wire logic readEnable = hit(rdAddr, usb_irq_pkg::ENABLE_ADDR);
	wire logic readLines = hit(rdAddr, usb_irq_pkg::LINE_STATUS_ADDR);

	logic [31:0] lineWord;
	always_comb begin
		lineWord = 32'h0;
		lineWord[usb_irq_pkg::LINE_LOW_BIT] = lines.low;
		lineWord[usb_irq_pkg::LINE_HIGH_BIT] = lines.high;
	end

	// R10 priority, clear and force read as zero
	assign rdValue = readStatus ? {22'h0, status} :
		readEnable ? {22'h0, enable} :
		readLines ? lineWord : 32'h0;

endmodule
`default_nettype wire

/* File: verification/usb_irq_props.sv */
// checker: bus answers and interrupt-line routing of the device interrupt block
`timescale 1ns/1ns
`default_nettype none
module usb_irq_props #(
	parameter int FRAME_CYCLES = 50
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// events and lines
	input wire logic [9:0] eventPulse,
	input wire logic lowPriorityIrqLine,
	input wire logic highPriorityIrqLine,
	input wire logic usbIrq
);
	// ************************************************************
	// shadow of written routing state
	// ************************************************************
	logic wrPend;
	logic [31:0] wrAddr;
	logic [9:0] enableShadow;
	logic [1:0] prioShadow;
	wire logic taken = hsel && hready && htrans[1];
	wire logic rdEnable = taken && !hwrite && haddr == usb_irq_pkg::ENABLE_ADDR;
	wire logic rdPrio = taken && !hwrite && haddr == usb_irq_pkg::PRIORITY_ADDR;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wrPend <= 1'b0;
			wrAddr <= 32'h0;
			enableShadow <= 10'h0;
			prioShadow <= 2'h0;
		end else if (hready) begin
			wrPend <= taken && hwrite;
			wrAddr <= haddr;
			if (wrPend && wrAddr == usb_irq_pkg::ENABLE_ADDR) begin
				enableShadow <= hwdata[9:0];
			end
			if (wrPend && wrAddr == usb_irq_pkg::PRIORITY_ADDR) begin
				prioShadow <= hwdata[1:0];
			end
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// ************************************************************
	// properties
	// ************************************************************
	a_lines_combined:
	assert property (usbIrq == (lowPriorityIrqLine || highPriorityIrqLine))
		else $error("usbIrq differs from the OR of both lines");
	a_disabled_quiet:
	assert property (enableShadow == 10'h0 |=> !lowPriorityIrqLine && !highPriorityIrqLine)
		else $error("line raised with every enable bit clear");
	a_event_low:
	assert property ((eventPulse & enableShadow) != 10'h0 && prioShadow == 2'h0
		|=> ##1 lowPriorityIrqLine) else $error("enabled event did not raise low line");
	a_default_low:
	assert property (prioShadow == 2'h0 |=> !highPriorityIrqLine)
		else $error("high line raised with default routing");
	a_both_no_high:
	assert property (prioShadow == 2'h3 |=> !highPriorityIrqLine)
		else $error("high line raised with both priority bits set");
	a_frame_high:
	assert property (eventPulse[0] && enableShadow[0] && prioShadow == 2'h1
		|=> ##1 highPriorityIrqLine) else $error("frame event missed high line");
	a_fast_high:
	assert property (eventPulse[1] && enableShadow[1] && prioShadow == 2'h2
		|=> ##1 highPriorityIrqLine) else $error("fast event missed high line");
	a_enable_readback:
	assert property (rdEnable |=> ##1 hreadyout && hrdata == {22'h0, enableShadow})
		else $error("enable read returned wrong value");
	a_prio_hidden:
	assert property (rdPrio |=> !hreadyout ##1 hreadyout && hrdata == 32'h0 && !hresp)
		else $error("priority read did not return zero");
endmodule
`default_nettype wire

/* File: verification/irq_vic_model.sv */
// partner: interrupt controller counting requests raised on the high line
`timescale 1ns/1ns
`default_nettype none
module irq_vic_model (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// request lines
	input wire usb_irq_pkg::irq_lines_type lines,
	// requests taken from the high line
	output logic [7:0] highRequests
);
	logic highSeen;
	// edge counted, since a level request is one service call
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			highSeen <= 1'b0;
			highRequests <= 8'h0;
		end else begin
			highSeen <= lines.high;
			highRequests <= highRequests + {7'h0, lines.high && !highSeen};
		end
	end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// testbench: register and routing scenarios for the device interrupt block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int FR = 50;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [9:0] eventPulse = 10'h0;
	wire logic hready;
	wire logic hresp;
	wire logic low;
	wire logic high;
	wire logic [31:0] hrdata;
	wire logic [7:0] highRequests;
	wire usb_irq_pkg::irq_lines_type lineBus = {low, high};
	int failures = 0;
	int checksDone = 0;
	int n;
	time t0;
	time t1;
	usb_device_irq_routing #(.FRAME_CYCLES(FR)) i_usb_device_irq_routing (.clock, .arst_n,
		.hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
		.hreadyout(hready), .hresp, .hrdata, .eventPulse, .lowPriorityIrqLine(low),
		.highPriorityIrqLine(high), .usbIrq());
	irq_vic_model i_irq_vic_model (.clock, .arst_n, .lines(lineBus), .highRequests);
	always #20 clock = ~clock;
	// ************************************************************
	// bus and compare tasks
	// ************************************************************
	task automatic results();
		if (failures == 0 && checksDone > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic waitReady(output logic [31:0] r);
		@(negedge clock);
		while (hready !== 1'b1) @(negedge clock);
		r = hrdata;
		@(posedge clock);
	endtask
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		waitReady(r);
		htrans <= 2'h0;
		hwdata <= d;
		waitReady(r);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask
	task automatic rdChk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0, r);
		check(r & m, e);
	endtask
	task automatic pulse(input logic [9:0] b);
		eventPulse <= b;
		@(posedge clock);
		eventPulse <= 10'h0;
	endtask
	task automatic lineChk(input logic [1:0] e);
		@(posedge clock);
		@(negedge clock);
		check({30'h0, high, low}, {30'h0, e});
		@(posedge clock);
	endtask
	// clear the frame bit, wait for the line to drop, then for the next rise
	task automatic frameRise(output time t);
		wr(usb_irq_pkg::CLEAR_ADDR, 32'h1);
		n = 0;
		while (high !== 1'b0 && n < 4) begin
			@(negedge clock);
			n++;
		end
		while (high !== 1'b1 && n < 2 * FR) begin
			@(negedge clock);
			n++;
		end
		t = $time;
		@(posedge clock);
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		rdChk(usb_irq_pkg::STATUS_ADDR, 32'hffffffff, 32'h10);
		rdChk(usb_irq_pkg::ENABLE_ADDR, 32'hffffffff, 32'h0);
		rdChk(32'he010c210, 32'hffffffff, 32'h0);
		wr(usb_irq_pkg::CLEAR_ADDR, 32'h3fe);
		wr(usb_irq_pkg::FORCE_ADDR, 32'h0);
		rdChk(usb_irq_pkg::STATUS_ADDR, 32'h3fe, 32'h0);
		wr(usb_irq_pkg::ENABLE_ADDR, 32'hffffffff);
		rdChk(usb_irq_pkg::ENABLE_ADDR, 32'hffffffff, 32'h3ff);
		wr(usb_irq_pkg::ENABLE_ADDR, 32'h3fe);
		lineChk(2'b00);
		wr(usb_irq_pkg::FORCE_ADDR, 32'h20);
		lineChk(2'b01);
		rdChk(usb_irq_pkg::STATUS_ADDR, 32'h3fe, 32'h20);
		wr(usb_irq_pkg::ENABLE_ADDR, 32'h1de);
		lineChk(2'b00);
		wr(usb_irq_pkg::CLEAR_ADDR, 32'h20);
		wr(usb_irq_pkg::ENABLE_ADDR, 32'h3fe);
		// reserved priority bits are always written as zero
		wr(usb_irq_pkg::PRIORITY_ADDR, 32'h2);
		pulse(10'h2);
		lineChk(2'b10);
		rdChk(usb_irq_pkg::PRIORITY_ADDR, 32'hffffffff, 32'h0);
		wr(usb_irq_pkg::PRIORITY_ADDR, 32'h3);
		lineChk(2'b01);
		check({24'h0, highRequests}, 32'h1);
		wr(usb_irq_pkg::PRIORITY_ADDR, 32'h0);
		lineChk(2'b01);
		// no per-endpoint state here, so nothing to clear first
		wr(usb_irq_pkg::CLEAR_ADDR, 32'h2);
		lineChk(2'b00);
		fork
			wr(usb_irq_pkg::CLEAR_ADDR, 32'h4);
			begin
				@(posedge clock);
				eventPulse <= 10'h4;
				@(posedge clock);
				eventPulse <= 10'h0;
			end
		join
		rdChk(usb_irq_pkg::STATUS_ADDR, 32'h3fe, 32'h4);
		wr(usb_irq_pkg::CLEAR_ADDR, 32'h4);
		wr(usb_irq_pkg::ENABLE_ADDR, 32'h1);
		wr(usb_irq_pkg::PRIORITY_ADDR, 32'h1);
		pulse(10'h1);
		lineChk(2'b10);
		// first rise may be stale if a tick met the clear, so time the later two
		frameRise(t0);
		frameRise(t0);
		frameRise(t1);
		check(32'(n <= FR + 2), 32'h1);
		check(32'((t1 - t0) / usb_irq_pkg::CLOCK_PERIOD_NS), 32'(FR));
		@(posedge clock);
		results();
	end
	initial begin
		repeat (5000) @(posedge clock);
		failures++;
		results();
	end
endmodule
bind usb_device_irq_routing usb_irq_props #(.FRAME_CYCLES(FRAME_CYCLES)) i_usb_irq_props (
	.clock, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
	.hresp, .hrdata, .eventPulse, .lowPriorityIrqLine, .highPriorityIrqLine, .usbIrq);
`default_nettype wire
